/* core/access_check.sv */
// Decides whether an access to one peripheral unit is served or faulted.
// Assumes a one-cycle request pulse with a unit index beside it.
`timescale 1ns/1ps
module access_check
   import clk_gate_pkg::*;
(
   input  wire logic [UNITS-1:0] gates,
   input  wire logic [1:0]       unit,
   input  wire logic             req,
   output logic                  grant,
   output logic                  fault
);
   import clk_gate_pkg::*;

   logic clocked;

   assign clocked = gates[unit];
   assign grant   = req & clocked;
   assign fault   = req & ~clocked;

endmodule : access_check

/* core/clk_gate_pkg.sv */
// Constants, register map and types shared by the sleep clock gating block.
// Assumes a 40 MHz system clock and a word-addressed register port.
package clk_gate_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [11:0] RUN_GATES_OFF   = 12'h100;
   localparam logic [11:0] SLEEP_GATES_OFF = 12'h110;
   localparam logic [11:0] DEEP_GATES_OFF  = 12'h120;
   localparam logic [11:0] CLK_CONFIG_OFF  = 12'h130;
   localparam logic [11:0] EVT_STATUS_OFF  = 12'h134;
   localparam logic [11:0] EVT_MASK_OFF    = 12'h138;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int WDT_POS  = 3;
   localparam int HIB_POS  = 6;
   localparam int RATE_LSB = 8;
   localparam int ADC_POS  = 16;
   localparam int PWM_POS  = 20;
   localparam int ACG_POS  = 0;
   localparam int EVT_FAULT_POS = 0;
   localparam int EVT_MODE_POS  = 1;

   // Writable bits; everything else is reserved and reads zero.
   localparam logic [31:0] SLEEP_WR_MASK = 32'h0011_0348;
   localparam logic [31:0] DEEP_WR_MASK  = 32'h0011_0048;
   localparam logic [31:0] CFG_WR_MASK   = 32'h0000_0001;
   localparam logic [31:0] EVT_WR_MASK   = 32'h0000_0003;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] GATES_RST = 32'h0000_0040;
   localparam logic [31:0] CFG_RST   = 32'h0000_0000;
   localparam logic [31:0] EVT_RST   = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Converter sample timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 25;
   localparam int SLOW_SAMPLE_NS  = 8000;
   localparam int FAST_SAMPLE_NS  = 4000;
   localparam logic [8:0] SLOW_SAMPLE_CYC =
      9'(SLOW_SAMPLE_NS / CLK_PERIOD_NS);
   localparam logic [8:0] FAST_SAMPLE_CYC =
      9'(FAST_SAMPLE_NS / CLK_PERIOD_NS);
   localparam logic [1:0] RATE_SLOW = 2'h0;
   localparam logic [1:0] RATE_FAST = 2'h1;
   localparam logic [1:0] RATE_MAX  = 2'h1;

   // Unit order in every gate vector: pwm, converter, hibernate, watchdog.
   localparam int UNITS = 4;

   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP  = 2'b10
   } power_mode_e;

   function automatic logic [UNITS-1:0] gates_of(input logic [31:0] r);
      gates_of = {r[PWM_POS], r[ADC_POS], r[HIB_POS], r[WDT_POS]};
   endfunction : gates_of

endpackage : clk_gate_pkg

/* core/gate_select.sv */
// Chooses which gate vector and rate field governs the unit clocks.
// Assumes all inputs are registers on the same clock.
`timescale 1ns/1ps
module gate_select
   import clk_gate_pkg::*;
(
   input  wire logic [31:0] run_gates,
   input  wire logic [31:0] sleep_gates,
   input  wire logic [31:0] deep_gates,
   input  wire logic        auto_clock_gating,
   input  wire power_mode_e mode,
   output logic [UNITS-1:0] gates,
   output logic [1:0]       rate
);
   import clk_gate_pkg::*;

   logic [31:0] chosen;
   logic [1:0]  asked;

   // Without auto gating the run register stays in force in every mode.
   assign chosen = !auto_clock_gating               ? run_gates   :
                   mode == MODE_SLEEP ? sleep_gates :
                   mode == MODE_DEEP  ? deep_gates  : run_gates;
   assign gates  = gates_of(chosen);
   // The deep register has no rate field, so deep sleep keeps sleep's.
   assign asked  = (auto_clock_gating && mode == MODE_DEEP) ?
                   sleep_gates[RATE_LSB +: 2] : chosen[RATE_LSB +: 2];
   // A request above the permitted maximum never raises the real rate.
   assign rate   = (asked > RATE_MAX) ? RATE_MAX : asked;

endmodule : gate_select

/* core/sleep_clock_gating.sv */
// Clock gating control for the peripheral units in run, sleep and deep
// sleep, with its register port, access fault check and event interrupt.
// Assumes mode requests and unit accesses come from logic on ref_clk.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps

// Function
// - A set gate bit clocks its unit; a clear bit stops it.
// - Access to an unclocked unit gives a bus fault instead.
// - Gate bits reset to zero unless stated otherwise.
// - Deep gating register resets with only hibernate bit set, read/write.
// - Deep gating register decodes at its own offset.
// - Bit 6 gates hibernate clock, read/write, resets to one.
// - Bit 3 gates watchdog clock, read/write, resets to zero.
// - Rate field bits 9:8: one gives 250k, zero gives 125k samples.
// - A rate above the permitted maximum never raises the real rate.
// - Run, sleep and deep registers apply in their own modes.
// - Sleep and deep registers govern only while auto gating is set.
// - Reserved bits read zero and ignore writes.
module sleep_clock_gating
   import clk_gate_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [11:0]      reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata_q,
   input  wire logic             sleep_req,
   input  wire logic             deep_sleep_req,
   input  wire logic             unit_req,
   input  wire logic [1:0]       unit_sel,
   output logic                  unit_grant_q,
   output logic                  unit_fault_q,
   output logic [UNITS-1:0]      unit_clk_en_q,
   output logic [1:0]            sample_rate_q,
   output logic                  sample_tick_q,
   output logic                  irq_q
);
   import clk_gate_pkg::*;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [31:0]  run_gates_q;
   logic [31:0]  sleep_gates_q;
   logic [31:0]  deep_gates_q;
   logic [31:0]  clk_config_q;
   logic [31:0]  evt_status_q;
   logic [31:0]  evt_mask_q;
   power_mode_e  mode_q;
   power_mode_e  mode_d;
   logic [8:0]   tick_cnt_q;
   logic [8:0]   tick_cnt_d;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   logic         wr_run;
   logic         wr_sleep;
   logic         wr_deep;
   logic         wr_cfg;
   logic         wr_status;
   logic         wr_mask;
   logic [31:0]  rd_mux;

   assign wr_run    = reg_wr && reg_addr == RUN_GATES_OFF;
   assign wr_sleep  = reg_wr && reg_addr == SLEEP_GATES_OFF;
   assign wr_deep   = reg_wr && reg_addr == DEEP_GATES_OFF;
   assign wr_cfg    = reg_wr && reg_addr == CLK_CONFIG_OFF;
   assign wr_status = reg_wr && reg_addr == EVT_STATUS_OFF;
   assign wr_mask   = reg_wr && reg_addr == EVT_MASK_OFF;

   // Unmapped offsets read zero; reserved bits are never stored.
   assign rd_mux =
      reg_addr == RUN_GATES_OFF   ? run_gates_q   :
      reg_addr == SLEEP_GATES_OFF ? sleep_gates_q :
      reg_addr == DEEP_GATES_OFF  ? deep_gates_q  :
      reg_addr == CLK_CONFIG_OFF  ? clk_config_q  :
      reg_addr == EVT_STATUS_OFF  ? evt_status_q  :
      reg_addr == EVT_MASK_OFF    ? evt_mask_q    : 32'h0000_0000;

   // ------------------------------------------------------------------
   // Gating register storage
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_gates_q   <= GATES_RST;
         sleep_gates_q <= GATES_RST;
         deep_gates_q  <= GATES_RST;
         clk_config_q  <= CFG_RST;
         evt_mask_q    <= EVT_RST;
      end else begin
         if (wr_run)
            run_gates_q   <= reg_wdata & SLEEP_WR_MASK;
         if (wr_sleep)
            sleep_gates_q <= reg_wdata & SLEEP_WR_MASK;
         if (wr_deep)
            deep_gates_q  <= reg_wdata & DEEP_WR_MASK;
         if (wr_cfg)
            clk_config_q  <= reg_wdata & CFG_WR_MASK;
         if (wr_mask)
            evt_mask_q    <= reg_wdata & EVT_WR_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         reg_rdata_q <= 32'h0000_0000;
      else
         reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
   end

   // ------------------------------------------------------------------
   // Power mode tracking
   // ------------------------------------------------------------------
   always_comb begin
      case ({deep_sleep_req, sleep_req})
         2'b00:   mode_d = MODE_RUN;
         2'b01:   mode_d = MODE_SLEEP;
         default: mode_d = MODE_DEEP;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         mode_q <= MODE_RUN;
      else
         mode_q <= mode_d;
   end

   // ------------------------------------------------------------------
   // Gate selection and unit clock enables
   // ------------------------------------------------------------------
   logic [UNITS-1:0] gates;
   logic [1:0]       rate;
   logic             auto_clock_gating;

   assign auto_clock_gating = clk_config_q[ACG_POS];

   gate_select u_select (
      .run_gates   (run_gates_q),
      .sleep_gates (sleep_gates_q),
      .deep_gates  (deep_gates_q),
      .auto_clock_gating         (auto_clock_gating),
      .mode        (mode_q),
      .gates       (gates),
      .rate        (rate)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         unit_clk_en_q <= gates_of(GATES_RST);
         sample_rate_q <= RATE_SLOW;
      end else begin
         unit_clk_en_q <= gates;
         sample_rate_q <= rate;
      end
   end

   // ------------------------------------------------------------------
   // Peripheral access check
   // ------------------------------------------------------------------
   logic grant;
   logic fault;

   // Judged against the enables the units really see this cycle.
   access_check u_check (
      .gates (unit_clk_en_q),
      .unit  (unit_sel),
      .req   (unit_req),
      .grant (grant),
      .fault (fault)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         unit_grant_q <= 1'b0;
         unit_fault_q <= 1'b0;
      end else begin
         unit_grant_q <= grant;
         unit_fault_q <= fault;
      end
   end

   // ------------------------------------------------------------------
   // Converter sample tick
   // ------------------------------------------------------------------
   logic [8:0] period;
   logic       adc_on;

   assign period = (sample_rate_q == RATE_FAST) ?
                   FAST_SAMPLE_CYC : SLOW_SAMPLE_CYC;
   assign adc_on = unit_clk_en_q[2];
   // The count restarts while the converter is unclocked, so the first
   // tick after enabling lands one full period later.
   assign tick_cnt_d = (!adc_on || tick_cnt_q == 9'h000) ?
                       period - 9'h001 : tick_cnt_q - 9'h001;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick_cnt_q    <= SLOW_SAMPLE_CYC - 9'h001;
         sample_tick_q <= 1'b0;
      end else begin
         tick_cnt_q    <= tick_cnt_d;
         sample_tick_q <= adc_on && tick_cnt_q == 9'h000;
      end
   end

   // ------------------------------------------------------------------
   // Event status and interrupt
   // ------------------------------------------------------------------
   logic [31:0] evt_set;
   logic [31:0] evt_clr;

   assign evt_set = {30'h0000_0000, mode_q != mode_d, fault};
   assign evt_clr = wr_status ? (reg_wdata & EVT_WR_MASK) : 32'h0000_0000;

   // A new event in the clearing cycle wins over the clear.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         evt_status_q <= EVT_RST;
         irq_q        <= 1'b0;
      end else begin
         evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
         irq_q        <= |(evt_status_q & ~evt_clr & evt_mask_q);
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence deep_write_s;
      wr_deep && reg_wdata[HIB_POS];
   endsequence

   sequence deep_read_s;
      reg_rd && reg_addr == DEEP_GATES_OFF;
   endsequence

   deep_reset_a: assert property (
      $fell(rst) |-> deep_gates_q == GATES_RST)
      else $error("deep gates did not reset to hibernate only");

   deep_read_a: assert property (
      deep_read_s |=> reg_rdata_q == $past(deep_gates_q))
      else $error("deep gates read back wrong");

   deep_store_a: assert property (
      wr_deep |=> deep_gates_q == ($past(reg_wdata) & DEEP_WR_MASK))
      else $error("deep gate write not stored");

   hib_write_a: assert property (
      deep_write_s |=> deep_gates_q[HIB_POS])
      else $error("hibernate gate write lost");

   wdt_gate_a: assert property (
      !$past(auto_clock_gating) |->
      unit_clk_en_q[0] == $past(run_gates_q[WDT_POS]))
      else $error("watchdog enable does not follow its gate");

   rsvd_zero_a: assert property (
      reg_rd && reg_addr == SLEEP_GATES_OFF |=>
      (reg_rdata_q & ~SLEEP_WR_MASK) == 32'h0000_0000)
      else $error("reserved bits read nonzero");

   run_only_a: assert property (
      !$past(auto_clock_gating) |->
      unit_clk_en_q == $past(gates_of(run_gates_q)))
      else $error("run gates not in force without auto gating");

   deep_apply_a: assert property (
      auto_clock_gating && mode_q == MODE_DEEP && !wr_deep && !wr_cfg |=>
      unit_clk_en_q == $past(gates_of(deep_gates_q)))
      else $error("deep gates not applied in deep sleep");

   access_fault_a: assert property (
      unit_req && !unit_clk_en_q[unit_sel] |=>
      unit_fault_q && !unit_grant_q)
      else $error("gated unit access did not fault");

   access_grant_a: assert property (
      unit_req && unit_clk_en_q[unit_sel] |=>
      unit_grant_q && !unit_fault_q)
      else $error("clocked unit access not granted");

   rate_cap_a: assert property (
      sample_rate_q <= RATE_MAX)
      else $error("sample rate above maximum");

   tick_gap_a: assert property (
      sample_tick_q |=> !sample_tick_q [*8])
      else $error("sample ticks too close");

   irq_level_a: assert property (
      |(evt_status_q & evt_mask_q) && !wr_status |=> irq_q)
      else $error("interrupt not raised for masked-in event");

endmodule : sleep_clock_gating

/* test/periph_model.sv */
// Model of the peripheral units that receive the gated clock enables.
// Assumes enables and sample pulses are registered on ref_clk.
`timescale 1ns/1ps
module periph_model
   import clk_gate_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [UNITS-1:0] unit_clk_en_q,
   input  wire logic             sample_tick_q,
   output logic [15:0]           tick_gap_q,
   output logic [15:0]           tick_count_q
);
   import clk_gate_pkg::*;

   localparam int ADC_BIT = 2;

   logic [15:0] cnt_q;

   // The converter's cycle counter only runs while its clock is on, so a
   // tick seen while gated off shows up as a stray count.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q        <= 16'h0;
         tick_gap_q   <= 16'h0;
         tick_count_q <= 16'h0;
      end else begin
         if (sample_tick_q) begin
            tick_count_q <= tick_count_q + 16'h1;
         end
         if (unit_clk_en_q[ADC_BIT]) begin
            if (sample_tick_q) begin
               tick_gap_q <= cnt_q + 16'h1;
               cnt_q      <= 16'h0;
            end else begin
               cnt_q <= cnt_q + 16'h1;
            end
         end
      end
   end
endmodule : periph_model

/* test/testbench.sv */
// Self-checking bench for the sleep clock gating block.
// Assumes the design package and the peripheral model are compiled first.
`timescale 1ns/1ps
module testbench;
   import clk_gate_pkg::*;

   logic        ref_clk        = 1'h0;
   logic        rst            = 1'h1;
   logic [11:0] reg_addr       = 12'h000;
   logic [31:0] reg_wdata      = 32'h0;
   logic        reg_wr         = 1'h0;
   logic        reg_rd         = 1'h0;
   logic        sleep_req      = 1'h0;
   logic        deep_sleep_req = 1'h0;
   logic        unit_req       = 1'h0;
   logic [1:0]  unit_sel       = 2'h0;
   logic [31:0] reg_rdata_q;
   logic        unit_grant_q;
   logic        unit_fault_q;
   logic [3:0]  unit_clk_en_q;
   logic [1:0]  sample_rate_q;
   logic        sample_tick_q;
   logic        irq_q;
   logic [15:0] tick_gap_q;
   logic [15:0] tick_count_q;
   logic [15:0] cnt_seen;
   logic [31:0] rd_q;
   int          n_fail  = 0;
   int          n_tests = 0;

   always #12.5 ref_clk = ~ref_clk;

   sleep_clock_gating u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata_q, .sleep_req, .deep_sleep_req,
      .unit_req, .unit_sel, .unit_grant_q, .unit_fault_q, .unit_clk_en_q,
      .sample_rate_q, .sample_tick_q, .irq_q);

   periph_model u_periph (.ref_clk, .rst, .unit_clk_en_q, .sample_tick_q,
      .tick_gap_q, .tick_count_q);

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge ref_clk);
      reg_wr    <= 1'h0;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [11:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge ref_clk);
      reg_rd   <= 1'h0;
      #1 rd_q = reg_rdata_q;
   endtask : rd

   task automatic acc(input logic [1:0] s, input logic g);
      @(posedge ref_clk);
      unit_req <= 1'h1;
      unit_sel <= s;
      @(posedge ref_clk);
      unit_req <= 1'h0;
      #1;
      chk(unit_grant_q, g);
      chk(unit_fault_q, !g);
   endtask : acc

   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : settle

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      rd(DEEP_GATES_OFF);
      chk(rd_q, 32'h0000_0040);
      rd(SLEEP_GATES_OFF);
      chk(rd_q, 32'h0000_0040);
      chk(unit_clk_en_q, 4'h2);
      chk(sample_rate_q, 2'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      wr(DEEP_GATES_OFF, 32'hffff_ffff);
      rd(DEEP_GATES_OFF);
      chk(rd_q, 32'h0011_0048);
      rd(SLEEP_GATES_OFF);
      chk(rd_q, 32'h0000_0040);
      wr(SLEEP_GATES_OFF, 32'hffff_ffff);
      rd(SLEEP_GATES_OFF);
      chk(rd_q, 32'h0011_0348);
      wr(12'h1fc, 32'hffff_ffff);
      rd(12'h1fc);
      chk(rd_q, 32'h0);
      wr(DEEP_GATES_OFF, 32'h0);
      rd(DEEP_GATES_OFF);
      chk(rd_q, 32'h0);
      wr(SLEEP_GATES_OFF, 32'h0000_0040);
      $display("test registers done");
   endtask : t_regs

   task automatic t_fault;
      wr(EVT_STATUS_OFF, 32'h3);
      wr(EVT_MASK_OFF, 32'h1);
      acc(2'h0, 1'h0);
      settle;
      chk(irq_q, 1'h1);
      rd(EVT_STATUS_OFF);
      chk(rd_q, 32'h1);
      wr(EVT_STATUS_OFF, 32'h1);
      settle;
      chk(irq_q, 1'h0);
      // Software enables the watchdog before touching it.
      wr(RUN_GATES_OFF, 32'h0000_0048);
      settle;
      chk(unit_clk_en_q, 4'h3);
      acc(2'h0, 1'h1);
      acc(2'h1, 1'h1);
      acc(2'h2, 1'h0);
      acc(2'h3, 1'h0);
      settle;
      chk(irq_q, 1'h1);
      wr(EVT_MASK_OFF, 32'h0);
      settle;
      chk(irq_q, 1'h0);
      wr(EVT_STATUS_OFF, 32'h3);
      $display("test fault done");
   endtask : t_fault

   task automatic t_modes;
      wr(SLEEP_GATES_OFF, 32'h0001_0048);
      wr(DEEP_GATES_OFF, 32'h0010_0040);
      wr(CLK_CONFIG_OFF, 32'h1);
      @(posedge ref_clk);
      sleep_req <= 1'h1;
      settle;
      chk(unit_clk_en_q, 4'h7);
      rd(EVT_STATUS_OFF);
      chk(rd_q, 32'h2);
      acc(2'h2, 1'h1);
      @(posedge ref_clk);
      deep_sleep_req <= 1'h1;
      settle;
      chk(unit_clk_en_q, 4'ha);
      acc(2'h3, 1'h1);
      acc(2'h0, 1'h0);
      @(posedge ref_clk);
      sleep_req      <= 1'h0;
      deep_sleep_req <= 1'h0;
      settle;
      chk(unit_clk_en_q, 4'h3);
      wr(CLK_CONFIG_OFF, 32'h0);
      @(posedge ref_clk);
      deep_sleep_req <= 1'h1;
      settle;
      chk(unit_clk_en_q, 4'h3);
      @(posedge ref_clk);
      deep_sleep_req <= 1'h0;
      wr(EVT_STATUS_OFF, 32'h3);
      $display("test modes done");
   endtask : t_modes

   // Each rate setting is held for two slow periods and more, so the
   // partial period left over from the change has passed.
   task automatic t_rate;
      logic [1:0] eff;
      for (int i = 0; i < 4; i++) begin
         wr(RUN_GATES_OFF, 32'h0001_0040 | (32'(i) << 8));
         repeat (800) @(posedge ref_clk);
         #1;
         eff = (i == 0) ? 2'h0 : 2'h1;
         chk(sample_rate_q, eff);
         chk(tick_gap_q, (eff == 2'h1) ? 16'd160 : 16'd320);
      end
      wr(RUN_GATES_OFF, 32'h0000_0040);
      settle;
      cnt_seen = tick_count_q;
      repeat (400) @(posedge ref_clk);
      #1;
      chk(tick_count_q, cnt_seen);
      $display("test rate done");
   endtask : t_rate

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("watchdog expired");
      close_out;
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'h0;
      t_reset;
      t_regs;
      t_fault;
      t_modes;
      t_rate;
      close_out;
   end
endmodule : testbench
